/* design/gie_regs.vh */
// Constants for the global interrupt enable control block
`ifndef GIE_REGS_VH
`define GIE_REGS_VH
`define GIE_OPCODE 12'h658
`define GIE_SEL_DIS 32'h0000_0000
`define GIE_SEL_EN 32'h0000_0001
`define GIE_SEL_STAT 32'h0000_0002
`define GIE_CTL_BIT 0
`define GIE_CTL_RESET 32'h0000_0001
`define GIE_SETTLE_CYC 2'h2
`define GIE_ST_IDLE 2'h0
`define GIE_ST_SETTLE 2'h1
`define GIE_ST_DONE 2'h2
`endif

/* design/gie_settle.v */
// Settle pipeline: holds the applied disable bit and counts settle cycles
`timescale 1ns/1ps
`include "gie_regs.vh"
module gie_settle (
  // Clock, reset, enable
  input wire mclk_i,
  input wire srst_i,
  input wire ce_i,
  // Control
  input wire load_i,
  input wire dis_i,
  // Status
  output reg dis_o,
  output reg busy_o
);
  reg [1:0] cnt;

  always @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      dis_o <= 1'b1;
      busy_o <= 1'b0;
      cnt <= 2'h0;
    end
    else if (ce_i)
    begin
      if (load_i)
      begin
        dis_o <= dis_i;
        busy_o <= 1'b1;
        cnt <= `GIE_SETTLE_CYC;
      end
      else if (cnt != 2'h0)
      begin
        cnt <= cnt - 2'h1;
        busy_o <= (cnt != 2'h1);
      end
    end
  end
endmodule // gie_settle

/* design/gie_ctl.v */
// Global interrupt enable control instruction execution unit
// Contract
// [RULE1] Selector 0 sets the disable bit
// [RULE2] Selector 1 clears the disable bit
// [RULE3] Selector 2 only reports, no change
// [RULE4] Destination gets previous enable state
// [RULE5] Changed state settles before completion
// [RULE6] Non-supervisor execution raises type fault
// [RULE7] Decode register-format opcode 658H
`timescale 1ns/1ps
`include "gie_regs.vh"
module gie_ctl (
  // Clock, reset, enable
  input wire mclk_i,
  input wire srst_i,
  input wire ce_i,
  // Instruction issue
  input wire issue_i,
  input wire [11:0] opcode_i,
  input wire reg_fmt_i,
  input wire [31:0] selector_operand_i,
  input wire [4:0] dst_idx_i,
  input wire supervisor_i,
  // Completion
  output reg done_o,
  output reg busy_o,
  output reg wb_en_o,
  output reg [4:0] wb_idx_o,
  output reg [31:0] wb_data_o,
  output reg privilege_type_fault_o,
  output reg invalid_operand_fault_o,
  // Interrupt control register state
  output reg [31:0] interrupt_control_register_o,
  output reg irq_accept_en_o
);
  // State codes
  localparam [1:0] ST_IDLE = `GIE_ST_IDLE;
  localparam [1:0] ST_SETTLE = `GIE_ST_SETTLE;
  localparam [1:0] ST_DONE = `GIE_ST_DONE;
  // Selector classes
  localparam [1:0] CLS_DIS = 2'h0;
  localparam [1:0] CLS_EN = 2'h1;
  localparam [1:0] CLS_STAT = 2'h2;
  localparam [1:0] CLS_BAD = 2'h3;

  // Current state
  reg [1:0] state;
  reg [31:0] icr;
  reg [4:0] idx;
  reg old_en;
  reg load;
  reg new_dis;
  // Next values
  reg [1:0] next_state;
  reg [31:0] next_icr;
  reg [4:0] next_idx;
  reg next_old_en;
  reg next_load;
  reg next_new_dis;
  reg next_done;
  reg next_busy;
  reg next_wb_en;
  reg [4:0] next_wb_idx;
  reg [31:0] next_wb_data;
  reg next_priv_fault;
  reg next_inv_fault;
  // Settle stage and decode
  wire settle_dis;
  wire settle_busy;
  wire hit;
  wire [1:0] cls;

  // Enable state is the inverse of the disable bit
  function en_of;
    input dis;
    begin
      en_of = ~dis;
    end
  endfunction

  // Whole word must match; stray high bits are not masked
  function [1:0] sel_class;
    input [31:0] sel;
    begin
      if (sel == `GIE_SEL_DIS)
        sel_class = CLS_DIS;
      else if (sel == `GIE_SEL_EN)
        sel_class = CLS_EN;
      else if (sel == `GIE_SEL_STAT)
        sel_class = CLS_STAT;
      else
        sel_class = CLS_BAD;
    end
  endfunction

  assign hit = issue_i && reg_fmt_i && (opcode_i == `GIE_OPCODE); // RULE7
  assign cls = sel_class(selector_operand_i);

  gie_settle u_settle (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .load_i(load),
    .dis_i(new_dis),
    .dis_o(settle_dis),
    .busy_o(settle_busy)
  );

  always @*
  begin
    next_state = state;
    next_icr = icr;
    next_idx = idx;
    next_old_en = old_en;
    next_load = 1'b0;
    next_new_dis = new_dis;
    next_done = 1'b0;
    next_busy = busy_o;
    next_wb_en = 1'b0;
    next_wb_idx = wb_idx_o;
    next_wb_data = wb_data_o;
    next_priv_fault = 1'b0;
    next_inv_fault = 1'b0;
    case (state)
      ST_IDLE:
      begin
        if (hit)
        begin
          next_idx = dst_idx_i;
          next_old_en = en_of(icr[`GIE_CTL_BIT]); // RULE4
          if (!supervisor_i)
          begin
            // Fault leaves the enable state untouched
            next_priv_fault = 1'b1; // RULE6
            next_done = 1'b1;
          end
          else
          begin
            case (cls)
              CLS_DIS:
              begin
                next_icr[`GIE_CTL_BIT] = 1'b1; // RULE1
                next_new_dis = 1'b1;
                next_load = 1'b1;
                next_busy = 1'b1;
                next_state = ST_SETTLE;
              end
              CLS_EN:
              begin
                next_icr[`GIE_CTL_BIT] = 1'b0; // RULE2
                next_new_dis = 1'b0;
                next_load = 1'b1;
                next_busy = 1'b1;
                next_state = ST_SETTLE;
              end
              CLS_STAT:
              begin
                next_busy = 1'b1; // RULE3
                next_state = ST_DONE;
              end
              default:
              begin
                // Undefined selectors fault rather than guess
                next_inv_fault = 1'b1;
                next_done = 1'b1;
              end
            endcase
          end
        end
      end
      ST_SETTLE:
      begin
        // Wait until the settle stage holds the new bit
        if (!load && !settle_busy && settle_dis == new_dis)
          next_state = ST_DONE; // RULE5
      end
      ST_DONE:
      begin
        next_wb_en = 1'b1;
        next_wb_idx = idx;
        next_wb_data = {31'h0000_0000, old_en}; // RULE4
        next_done = 1'b1;
        next_busy = 1'b0;
        next_state = ST_IDLE;
      end
      default:
        next_state = ST_IDLE;
    endcase
  end

  always @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      state <= ST_IDLE;
      icr <= `GIE_CTL_RESET;
      idx <= 5'h00;
      old_en <= 1'b0;
      load <= 1'b0;
      new_dis <= 1'b1;
      done_o <= 1'b0;
      busy_o <= 1'b0;
      wb_en_o <= 1'b0;
      wb_idx_o <= 5'h00;
      wb_data_o <= 32'h0000_0000;
      privilege_type_fault_o <= 1'b0;
      invalid_operand_fault_o <= 1'b0;
      interrupt_control_register_o <= `GIE_CTL_RESET;
      irq_accept_en_o <= 1'b0;
    end
    else if (ce_i)
    begin
      // Low enable holds every register, pulses included
      state <= next_state;
      icr <= next_icr;
      idx <= next_idx;
      old_en <= next_old_en;
      load <= next_load;
      new_dis <= next_new_dis;
      done_o <= next_done;
      busy_o <= next_busy;
      wb_en_o <= next_wb_en;
      wb_idx_o <= next_wb_idx;
      wb_data_o <= next_wb_data;
      privilege_type_fault_o <= next_priv_fault;
      invalid_operand_fault_o <= next_inv_fault;
      interrupt_control_register_o <= icr;
      // Acceptance follows the settled copy, not the register
      irq_accept_en_o <= en_of(settle_dis); // RULE5
    end
  end
endmodule // gie_ctl

/* tb/gie_ctl_monitor.sv */
// Assertion checker for the global interrupt enable unit
`timescale 1ns/1ps
module gie_ctl_monitor (
  // Clock and issue side
  input logic mclk_i,
  input logic srst_i,
  input logic ce_i,
  input logic issue_i,
  input logic [11:0] opcode_i,
  input logic reg_fmt_i,
  input logic [31:0] selector_operand_i,
  input logic supervisor_i,
  // Completion side
  input logic done_o,
  input logic busy_o,
  input logic wb_en_o,
  input logic [31:0] wb_data_o,
  input logic privilege_type_fault_o,
  input logic [31:0] interrupt_control_register_o,
  input logic irq_accept_en_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  wire t = ce_i && issue_i && !busy_o && reg_fmt_i;
  wire g = t && opcode_i == 12'h658;
  wire s = g && supervisor_i;
  wire [31:0] sel = selector_operand_i;
  wire d = interrupt_control_register_o[0];
  AST_DIS: assert property (s && sel == 0 |-> ##6 done_o && d)
    else $error("disable did not set the bit");
  AST_EN: assert property (s && sel == 1 |-> ##6 done_o && !d)
    else $error("enable did not clear the bit");
  AST_STAT: assert property (s && sel == 2 |-> ##2 done_o && $stable(d))
    else $error("status changed state");
  AST_OLD: assert property (s && sel < 3 |-> ##[2:6] wb_en_o)
    else $error("no writeback");
  AST_SETTLED: assert property (done_o |-> irq_accept_en_o == !d)
    else $error("state not settled at done");
  AST_PRIV: assert property (g && !supervisor_i |=> privilege_type_fault_o && !wb_en_o)
    else $error("missing type fault");
  AST_OPC: assert property (t && opcode_i != 12'h658 |=> !busy_o)
    else $error("foreign opcode taken");
endmodule // gie_ctl_monitor
bind gie_ctl gie_ctl_monitor mon (.*);

/* tb/testbench.sv */
// Self-checking testbench for the global interrupt enable unit
`timescale 1ns/1ps
module testbench;
  logic mclk_i = 0, srst_i = 1, issue_i = 0, sup = 1, ce = 1, fmt = 1;
  logic [4:0] dst = 5'h3, widx;
  logic done_o, busy_o, wb_en, flt, bad_op, irq;
  logic [11:0] op = 12'h658;
  logic [31:0] sel = 0, wb, icr;
  int bad_count = 0, num_checks = 0, n;
  always #5 mclk_i = ~mclk_i;
  gie_ctl uut (.mclk_i(mclk_i), .srst_i(srst_i), .ce_i(ce), .issue_i(issue_i),
    .opcode_i(op), .reg_fmt_i(fmt), .selector_operand_i(sel), .dst_idx_i(dst),
    .supervisor_i(sup), .done_o(done_o), .busy_o(busy_o), .wb_en_o(wb_en), .wb_idx_o(widx),
    .wb_data_o(wb), .privilege_type_fault_o(flt), .invalid_operand_fault_o(bad_op),
    .interrupt_control_register_o(icr), .irq_accept_en_o(irq));
  task chk(string s, logic [31:0] a, logic [31:0] e);
    num_checks++;
    if (a !== e)
    begin
      $display("Error %s expected %h seen %h", s, e, a);
      bad_count++;
    end
  endtask
  // Issue one instruction, wait bounded for completion
  task go(logic [31:0] s, logic u);
    sel = s;
    sup = u;
    issue_i = 1;
    @(negedge mclk_i);
    issue_i = 0;
    // Take edge counts as cycle one
    n = 1;
    while (done_o !== 1'b1 && n < 20)
    begin
      @(negedge mclk_i);
      n++;
    end
  endtask
  task t_en;
    go(32'h1, 1);
    chk("cycles", n, 6);
    chk("old", wb, 32'h0);
    chk("dis_bit", icr[0], 1'b0);
    chk("accept", irq, 1'b1);
  endtask
  task t_stat;
    dst = 5'h1A;
    go(32'h2, 1);
    chk("cycles", n, 2);
    chk("old", wb, 32'h1);
    chk("idx", widx, 5'h1A);
    dst = 5'h3;
  endtask
  // Issue while frozen must not be taken
  task t_ce;
    @(negedge mclk_i);
    ce = 0;
    go(32'h0, 1);
    chk("frozen", {busy_o, done_o, icr[0], irq}, 4'h1);
    ce = 1;
  endtask
  task t_bad;
    go(32'h3, 1);
    chk("inv", {bad_op, flt, wb_en, icr[0]}, 4'h9);
  endtask
  task t_flt_dis;
    go(32'h0, 0);
    chk("fault", {flt, wb_en, icr[0]}, 3'h4);
    @(negedge mclk_i);
    go(32'h0, 1);
    chk("old", wb, 32'h1);
    chk("state", {icr[0], irq}, 2'h2);
  endtask
  task t_op;
    op = 12'h65B;
    go(32'h1, 1);
    chk("busy", {busy_o, done_o, icr[0]}, 3'h1);
    op = 12'h658;
    fmt = 0;
    go(32'h1, 1);
    chk("fmt", {busy_o, done_o, icr[0]}, 3'h1);
    fmt = 1;
  endtask
  task end_sim;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    #5000;
    bad_count++;
    end_sim;
  end
  initial
  begin
    repeat (6) @(posedge mclk_i);
    @(negedge mclk_i);
    srst_i = 0;
    t_en;
    t_stat;
    t_ce;
    t_flt_dis;
    t_bad;
    t_op;
    end_sim;
  end
endmodule // testbench
